// ### hdl/osdt_attr_resolve.sv
// osdt_attr_resolve: turns one stored element word into display attributes
// assumes the caller registers the result; purely combinational

`timescale 1ns/1ps
module osdt_attr_resolve (
   input wire osdt_pkg::osdt_prop_t prop,
   input wire logic [8:0] mcBase,
   output osdt_pkg::osdt_attr_t attr
);
   import osdt_pkg::*;

   // ==========================================================
   // resolve
   always_comb begin
      attr.multicolour = !prop.fontRom && (prop.code >= mcBase); // [R15]
      attr.fromRom = prop.fontRom; // [R21]
      attr.code = prop.code;
      // indices only: the colour tables live on the colour page
      attr.colourSel = prop.foreIndex; // [R12] [R13] [R14] [R17]
      // a palette carries its own background entry
      attr.backSel = attr.multicolour ? 3'h0 : prop.backIndex; // [R13] [R14]
      attr.foreBlink = prop.blink == BLINK_FORE; // [R20]
      attr.inverse = prop.blink == BLINK_INV; // [R20]
      attr.swapBlink = prop.blink == BLINK_SWAP; // [R20]
      attr.charShadow = prop.shadow;
      attr.backClear = prop.backClear;
      attr.foreClear = prop.foreClear;
      attr.backBlend = prop.backBlend;
      attr.foreBlend = prop.foreBlend;
   end

endmodule

// ### hdl/osdt_pkg.sv
// osdt_pkg: constants, field layouts and carrier types of the osd text layer
// assumes one pixel-rate clock and byte-wide register subaddresses

package osdt_pkg;

   // ==========================================================
   // sizes
   localparam int MAX_ELEMS = 1024;
   localparam int ADDR_W = 10;
   localparam int PROP_REGS = 3;
   localparam int FLAGS_W = 7;
   localparam int ANC_HI_W = 3;
   localparam int FRES_W = 5;
   localparam int BLINK_FRAMES = 16;

   // ==========================================================
   // register subaddresses
   localparam logic [7:0] A_COLS = 8'h00;
   localparam logic [7:0] A_ROWS = 8'h01;
   localparam logic [7:0] A_CUR_COL = 8'h02;
   localparam logic [7:0] A_CUR_ROW = 8'h03;
   localparam logic [7:0] A_ANC_XL = 8'h04;
   localparam logic [7:0] A_ANC_XH = 8'h05;
   localparam logic [7:0] A_ANC_YL = 8'h06;
   localparam logic [7:0] A_ANC_YH = 8'h07;
   localparam logic [7:0] A_FRES_H = 8'h08;
   localparam logic [7:0] A_FRES_V = 8'h09;
   localparam logic [7:0] A_CTRL = 8'h0A;
   localparam logic [7:0] A_DROP = 8'h0B;
   localparam logic [7:0] A_FLAGS = 8'h0C;
   localparam logic [7:0] A_COLOUR = 8'h0D;
   localparam logic [7:0] A_GLYPH = 8'h0E;
   localparam logic [7:0] A_MCB_HI = 8'h0F;
   localparam logic [7:0] A_MCB_LO = 8'h10;
   localparam logic [7:0] A_MASK = 8'h11;
   localparam logic [7:0] A_MASK_EXT = 8'h12;
   // index 0 = glyph low, 1 = colour select, 2 = attribute flags
   localparam logic [7:0] PROP_ADDR [PROP_REGS] = '{A_GLYPH, A_COLOUR, A_FLAGS};

   // ==========================================================
   // field positions
   localparam int CTRL_ZOOM_LSB = 0;
   localparam int CTRL_ZOOM_MSB = 1;
   localparam int CTRL_ROT = 2;
   localparam int CTRL_MIRH = 3;
   localparam int CTRL_MIRV = 4;
   localparam int CTRL_SHADOW = 5;
   localparam int CTRL_EN = 6;
   localparam int DROP_W_LSB = 4;
   localparam int DROP_W_MSB = 7;
   localparam int DROP_H_LSB = 0;
   localparam int DROP_H_MSB = 3;
   localparam int WMODE_LSB = 0;
   localparam int WMODE_MSB = 2;
   localparam int MASK_CODE = 3;
   localparam int MASK_ROM = 4;
   localparam int MASK_FORE = 5;
   localparam int MASK_BACK = 6;
   localparam int EXT_BLINK = 0;
   localparam int EXT_SHADOW = 1;
   localparam int EXT_BCLR = 2;
   localparam int EXT_FCLR = 3;
   localparam int EXT_BBL = 4;
   localparam int EXT_FBL = 5;

   // ==========================================================
   // reset values
   localparam logic [7:0] RST_DIM = 8'h01;
   localparam logic [7:0] RST_CURSOR = 8'h00;
   localparam logic [4:0] RST_FRES_H = 5'h0C;
   localparam logic [4:0] RST_FRES_V = 5'h12;
   localparam logic [6:0] RST_CTRL = 7'h00;
   localparam logic [6:0] RST_MASK = 7'h78;
   localparam logic [5:0] RST_MASK_EXT = 6'h3F;
   localparam logic [8:0] RST_MCB = 9'h100;

   // ==========================================================
   // blink codes
   localparam logic [1:0] BLINK_OFF = 2'h0;
   localparam logic [1:0] BLINK_FORE = 2'h1;
   localparam logic [1:0] BLINK_INV = 2'h2;
   localparam logic [1:0] BLINK_SWAP = 2'h3;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      RUN_IDLE = 3'h1,
      RUN_CORE = 3'h2,
      RUN_SHAD = 3'h4
   } osdt_run_t;

   typedef struct packed {
      logic [1:0] blink;
      logic shadow;
      logic backClear;
      logic foreClear;
      logic backBlend;
      logic foreBlend;
      logic [2:0] backIndex;
      logic [2:0] foreIndex;
      logic fontRom;
      logic [8:0] code;
   } osdt_prop_t;

   typedef struct packed {
      logic multicolour;
      logic fromRom;
      logic [8:0] code;
      logic [2:0] colourSel;
      logic [2:0] backSel;
      logic foreBlink;
      logic inverse;
      logic swapBlink;
      logic charShadow;
      logic backClear;
      logic foreClear;
      logic backBlend;
      logic foreBlend;
   } osdt_attr_t;

   typedef struct packed {
      logic active;
      logic shadowArea;
      logic foreHidden;
      logic swapColours;
      logic [4:0] glyphCol;
      logic [4:0] glyphRow;
      osdt_attr_t attr;
   } osdt_pixel_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } osdt_regreq_t;

   typedef struct packed {
      logic pixEn;
      logic lineStart;
      logic frameStart;
      logic [10:0] hPos;
      logic [10:0] vPos;
   } osdt_scan_t;

   typedef struct packed {
      osdt_run_t st;
      logic [1:0] z;
      logic [4:0] g;
      logic [7:0] c;
      logic [5:0] s;
   } osdt_axis_t;

   localparam osdt_axis_t AXIS_IDLE = '{st: RUN_IDLE, default: '0};

   // bit 2 = flags, bit 1 = colour select, bit 0 = glyph low
   function automatic logic [2:0] wmodeActive(logic [2:0] wm);
      case (wm)
         3'h1: return 3'h1;
         3'h2: return 3'h2;
         3'h3: return 3'h4;
         3'h4: return 3'h6;
         3'h5: return 3'h5;
         3'h6: return 3'h3;
         default: return 3'h7;
      endcase
   endfunction

endpackage

// ### hdl/osdt_text_window.sv
// osdt_text_window: osd text window ram, cursor write path and text placement
// assumes decoded byte register strokes and a scan position on the same clock
//
// Function
// [R01] window width times height never exceeds 1024 elements; the code does not limit cols and rows, elements past the ram end are dropped
// [R02] any element is addressed directly by column and row cursors
// [R03] anchor position is in pixels, window size in characters
// [R04] pixel size is characters times zoom times font resolution per axis
// [R05] text layer zooms 1 to 4 by pixel repetition, own setting
// [R06] window shadow extends area by drop size times zoom
// [R07] optional quarter turn clockwise plus independent horizontal and vertical mirror
// [R08] transposition is internal; width and height swap; shadow hidden
// [R09] cursor steps right after each element write, row end goes next row
// [R10] cursor column and row are readable at any time
// [R11] each element holds a 23-bit property word for one character
// [R12] colour fields are indices into global 24-bit colour tables
// [R13] single-colour: 3-bit fore index and 3-bit back index
// [R14] multicolour: shared field picks one of eight four-colour palettes
// [R15] multicolour when code is at or above the multicolour base; the code applies this to ram glyphs only, rom glyphs stay single-colour
// [R16] property word layout across flags, colour select and glyph low bytes
// [R17] colour tables reside on a separate colour register page
// [R18] commit only after all write-mode active bytes are rewritten
// [R19] commit updates only masked-in attributes, keeps the rest
// [R20] blink codes: off, fore blink, inverse, swap blink
// [R21] font source 1 fetches from rom, 0 from ram
// [R22] cursor wraps from last element to first element of first row
// [R23] host sets dimensions and cursor before streaming property bytes

`timescale 1ns/1ps
module osdt_text_window (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire osdt_pkg::osdt_regreq_t regReq,
   output logic [7:0] regRdata,
   input wire osdt_pkg::osdt_scan_t scan,
   output osdt_pkg::osdt_pixel_t pixOut
);
   import osdt_pkg::*;

   // ==========================================================
   // helpers
   function automatic logic [15:0] elemIndex(logic [7:0] r, logic [7:0] c, logic [7:0] w);
      return ({8'h00, r} * {8'h00, w}) + {8'h00, c};
   endfunction

   function automatic logic [7:0] flipIdx(logic [7:0] v, logic [7:0] n, logic en);
      return en ? n - v - 8'h01 : v;
   endfunction

   function automatic osdt_prop_t expandMask(logic [6:0] m, logic [5:0] x);
      osdt_prop_t r;
      r.blink = {2{x[EXT_BLINK]}};
      r.shadow = x[EXT_SHADOW];
      r.backClear = x[EXT_BCLR];
      r.foreClear = x[EXT_FCLR];
      r.backBlend = x[EXT_BBL];
      r.foreBlend = x[EXT_FBL];
      r.backIndex = {3{m[MASK_BACK]}};
      r.foreIndex = {3{m[MASK_FORE]}};
      r.fontRom = m[MASK_ROM];
      r.code = {9{m[MASK_CODE]}};
      return r;
   endfunction

   // one axis of the scan: zoom repeat, glyph pixel, character, then shadow tail
   function automatic osdt_axis_t stepAxis(osdt_axis_t a, logic start, logic [7:0] chars,
                                           logic [4:0] glyph, logic [5:0] shad, logic [1:0] zm);
      osdt_axis_t n;
      n = a;
      case (a.st)
         RUN_IDLE: begin
            if (start) begin
               n = AXIS_IDLE;
               n.st = RUN_CORE;
            end
         end
         RUN_CORE: begin
            if (a.z != zm) begin
               n.z = a.z + 2'h1; // [R05]
            end else begin
               n.z = 2'h0;
               if (a.g != glyph - 5'h01) begin
                  n.g = a.g + 5'h01; // [R04]
               end else begin
                  n.g = 5'h00;
                  if (a.c != chars - 8'h01) begin
                     n.c = a.c + 8'h01;
                  end else begin
                     n.st = (shad != 6'h00) ? RUN_SHAD : RUN_IDLE;
                  end
               end
            end
         end
         RUN_SHAD: begin
            if (a.s != shad - 6'h01) begin
               n.s = a.s + 6'h01; // [R06]
            end else begin
               n.st = RUN_IDLE;
            end
         end
         default: begin
            n = AXIS_IDLE;
         end
      endcase
      return n;
   endfunction

   // ==========================================================
   // registers
   osdt_prop_t winRam [MAX_ELEMS]; // [R11]
   logic [7:0] colsReg, rowsReg, curColReg, curRowReg;
   logic [10:0] ancXReg, ancYReg;
   logic [4:0] fResHReg, fResVReg;
   logic [6:0] ctrlReg, flagsReg, maskReg;
   logic [7:0] dropReg, colourReg, glyphReg;
   logic [8:0] mcbReg;
   logic [5:0] maskExtReg;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         colsReg <= RST_DIM;
         rowsReg <= RST_DIM;
         ancXReg <= '0;
         ancYReg <= '0;
         fResHReg <= RST_FRES_H;
         fResVReg <= RST_FRES_V;
         ctrlReg <= RST_CTRL;
         dropReg <= '0;
         flagsReg <= '0;
         colourReg <= '0;
         glyphReg <= '0;
         mcbReg <= RST_MCB;
         maskReg <= RST_MASK;
         maskExtReg <= RST_MASK_EXT;
      end else if (ce && regReq.wr) begin
         case (regReq.addr)
            A_COLS: colsReg <= regReq.wdata; // [R01]
            A_ROWS: rowsReg <= regReq.wdata; // [R01]
            A_ANC_XL: ancXReg[7:0] <= regReq.wdata; // [R03]
            A_ANC_XH: ancXReg[10:8] <= regReq.wdata[ANC_HI_W-1:0];
            A_ANC_YL: ancYReg[7:0] <= regReq.wdata;
            A_ANC_YH: ancYReg[10:8] <= regReq.wdata[ANC_HI_W-1:0];
            A_FRES_H: fResHReg <= regReq.wdata[FRES_W-1:0];
            A_FRES_V: fResVReg <= regReq.wdata[FRES_W-1:0];
            A_CTRL: ctrlReg <= regReq.wdata[6:0];
            A_DROP: dropReg <= regReq.wdata;
            A_FLAGS: flagsReg <= regReq.wdata[FLAGS_W-1:0]; // [R16]
            A_COLOUR: colourReg <= regReq.wdata; // [R16]
            A_GLYPH: glyphReg <= regReq.wdata; // [R16]
            A_MCB_HI: mcbReg[8] <= regReq.wdata[0];
            A_MCB_LO: mcbReg[7:0] <= regReq.wdata;
            A_MASK: maskReg <= regReq.wdata[6:0];
            A_MASK_EXT: maskExtReg <= regReq.wdata[5:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // property commit
   logic [2:0] wrSet, actSet, pendReg, pendAfter;
   logic full, commit;
   logic [15:0] curIdx;
   osdt_prop_t propNow, wMask, oldWord;

   for (genvar gi = 0; gi < PROP_REGS; gi++) begin : g_wr
      assign wrSet[gi] = regReq.wr && (regReq.addr == PROP_ADDR[gi]);
   end

   // the byte written this cycle takes part in the word it completes
   assign propNow = {wrSet[2] ? regReq.wdata[FLAGS_W-1:0] : flagsReg,
                     wrSet[1] ? regReq.wdata : colourReg,
                     wrSet[0] ? regReq.wdata : glyphReg}; // [R16]
   assign actSet = wmodeActive(maskReg[WMODE_MSB:WMODE_LSB]);
   assign pendAfter = (pendReg | wrSet) & actSet;
   assign full = |(wrSet & actSet) && (pendAfter == actSet); // [R18]
   assign curIdx = elemIndex(curRowReg, curColReg, colsReg);
   // elements past the ram end are dropped, cursor stays put
   assign commit = ce && full && (curIdx < MAX_ELEMS); // [R01]
   assign wMask = expandMask(maskReg, maskExtReg);
   assign oldWord = winRam[curIdx[ADDR_W-1:0]];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pendReg <= '0;
      end else if (ce) begin
         if (regReq.wr && regReq.addr == A_MASK) begin
            pendReg <= '0;
         end else if (full) begin
            pendReg <= '0; // [R18]
         end else begin
            pendReg <= pendAfter;
         end
      end
   end

   // no reset on the ram: contents are undefined until written
   always_ff @(posedge clk) begin
      if (commit) begin
         winRam[curIdx[ADDR_W-1:0]] <= (oldWord & ~wMask) | (propNow & wMask); // [R19]
      end
   end

   // ==========================================================
   // cursor
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         curColReg <= RST_CURSOR;
         curRowReg <= RST_CURSOR;
      end else if (ce) begin
         if (regReq.wr && regReq.addr == A_CUR_COL) begin
            curColReg <= regReq.wdata; // [R02]
         end else if (regReq.wr && regReq.addr == A_CUR_ROW) begin
            curRowReg <= regReq.wdata; // [R02]
         end else if (commit) begin
            if ({1'b0, curColReg} + 9'h001 < {1'b0, colsReg}) begin
               curColReg <= curColReg + 8'h01; // [R09]
            end else begin
               curColReg <= 8'h00; // [R09]
               if ({1'b0, curRowReg} + 9'h001 < {1'b0, rowsReg}) begin
                  curRowReg <= curRowReg + 8'h01;
               end else begin
                  curRowReg <= 8'h00; // [R22]
               end
            end
         end
      end
   end

   // ==========================================================
   // readback
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         regRdata <= '0;
      end else if (ce && regReq.rd) begin
         case (regReq.addr)
            A_COLS: regRdata <= colsReg;
            A_ROWS: regRdata <= rowsReg;
            A_CUR_COL: regRdata <= curColReg; // [R10]
            A_CUR_ROW: regRdata <= curRowReg; // [R10]
            A_ANC_XL: regRdata <= ancXReg[7:0];
            A_ANC_XH: regRdata <= {5'h00, ancXReg[10:8]};
            A_ANC_YL: regRdata <= ancYReg[7:0];
            A_ANC_YH: regRdata <= {5'h00, ancYReg[10:8]};
            A_FRES_H: regRdata <= {3'h0, fResHReg};
            A_FRES_V: regRdata <= {3'h0, fResVReg};
            A_CTRL: regRdata <= {1'b0, ctrlReg};
            A_DROP: regRdata <= dropReg;
            A_FLAGS: regRdata <= {1'b0, flagsReg};
            A_COLOUR: regRdata <= colourReg;
            A_GLYPH: regRdata <= glyphReg;
            A_MCB_HI: regRdata <= {7'h00, mcbReg[8]};
            A_MCB_LO: regRdata <= mcbReg[7:0];
            A_MASK: regRdata <= {1'b0, maskReg};
            A_MASK_EXT: regRdata <= {2'h0, maskExtReg};
            default: regRdata <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // scan geometry
   logic en, rot, shadowOn;
   logic [1:0] zoomSel;
   logic [2:0] zoomFac;
   logic [7:0] charsW, charsH;
   logic [4:0] glyphW, glyphH;
   logic [5:0] shadW, shadH;
   osdt_axis_t hAxis, vAxis;

   assign en = ctrlReg[CTRL_EN];
   assign zoomSel = ctrlReg[CTRL_ZOOM_MSB:CTRL_ZOOM_LSB]; // [R05]
   assign zoomFac = {1'b0, zoomSel} + 3'h1;
   assign rot = ctrlReg[CTRL_ROT]; // [R07]
   // the drop area is not shown while rotated
   assign shadowOn = ctrlReg[CTRL_SHADOW] && !rot; // [R08]
   assign charsW = rot ? rowsReg : colsReg; // [R08]
   assign charsH = rot ? colsReg : rowsReg; // [R08]
   assign glyphW = rot ? fResVReg : fResHReg; // [R04]
   assign glyphH = rot ? fResHReg : fResVReg; // [R04]
   assign shadW = shadowOn ? {2'h0, dropReg[DROP_W_MSB:DROP_W_LSB]} * {3'h0, zoomFac} : 6'h00; // [R06]
   assign shadH = shadowOn ? {2'h0, dropReg[DROP_H_MSB:DROP_H_LSB]} * {3'h0, zoomFac} : 6'h00; // [R06]

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hAxis <= AXIS_IDLE;
      end else if (ce) begin
         if (scan.lineStart || !en) begin
            hAxis <= AXIS_IDLE;
         end else if (scan.pixEn) begin
            hAxis <= stepAxis(hAxis, en && scan.hPos == ancXReg, charsW, glyphW, shadW, zoomSel); // [R03]
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         vAxis <= AXIS_IDLE;
      end else if (ce) begin
         if (scan.frameStart || !en) begin
            vAxis <= AXIS_IDLE;
         end else if (scan.lineStart) begin
            vAxis <= stepAxis(vAxis, en && scan.vPos == ancYReg, charsH, glyphH, shadH, zoomSel); // [R03]
         end
      end
   end

   // ==========================================================
   // transposition of matrix and glyph access
   logic [7:0] rCol, rRow, sCol, sRow, rgCol, rgRow;
   logic [4:0] gCol, gRow;
   logic [15:0] dispIdx;
   osdt_prop_t dispWord;
   osdt_attr_t attrNow;

   always_comb begin
      rCol = rot ? vAxis.c : hAxis.c; // [R07]
      rRow = rot ? flipIdx(hAxis.c, rowsReg, 1'b1) : vAxis.c; // [R07]
      rgCol = rot ? {3'h0, vAxis.g} : {3'h0, hAxis.g};
      rgRow = rot ? flipIdx({3'h0, hAxis.g}, {3'h0, fResVReg}, 1'b1) : {3'h0, vAxis.g};
      sCol = flipIdx(rCol, colsReg, ctrlReg[CTRL_MIRH]); // [R07]
      sRow = flipIdx(rRow, rowsReg, ctrlReg[CTRL_MIRV]); // [R07]
      gCol = 5'(flipIdx(rgCol, {3'h0, fResHReg}, ctrlReg[CTRL_MIRH]));
      gRow = 5'(flipIdx(rgRow, {3'h0, fResVReg}, ctrlReg[CTRL_MIRV]));
   end

   // cursor indexing is untouched: only the display side is transposed
   assign dispIdx = elemIndex(sRow, sCol, colsReg); // [R08]
   assign dispWord = (dispIdx < MAX_ELEMS) ? winRam[dispIdx[ADDR_W-1:0]] : '0;

   osdt_attr_resolve u_resolve (
      .prop(dispWord),
      .mcBase(mcbReg),
      .attr(attrNow)
   );

   // ==========================================================
   // blink phase
   logic [4:0] blinkCntReg;
   logic blinkPhaseReg;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         blinkCntReg <= '0;
         blinkPhaseReg <= 1'b0;
      end else if (ce && scan.frameStart) begin
         if (blinkCntReg == 5'(BLINK_FRAMES - 1)) begin
            blinkCntReg <= '0;
            blinkPhaseReg <= !blinkPhaseReg;
         end else begin
            blinkCntReg <= blinkCntReg + 5'h01;
         end
      end
   end

   // ==========================================================
   // pixel output
   logic inCore;

   assign inCore = hAxis.st == RUN_CORE && vAxis.st == RUN_CORE;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pixOut <= '0;
      end else if (ce) begin
         pixOut.active <= inCore;
         pixOut.shadowArea <= shadowOn && !inCore && hAxis.st != RUN_IDLE && vAxis.st != RUN_IDLE; // [R06]
         pixOut.foreHidden <= attrNow.foreBlink && blinkPhaseReg; // [R20]
         pixOut.swapColours <= attrNow.inverse || (attrNow.swapBlink && blinkPhaseReg); // [R20]
         pixOut.glyphCol <= gCol;
         pixOut.glyphRow <= gRow;
         pixOut.attr <= attrNow;
      end
   end

endmodule

// ### test/osdt_host_model.sv
// osdt_host_model: register host writing and reading the text layer bytes
// assumes the bench calls its tasks; strokes change on the falling edge
`timescale 1ns/1ps
module osdt_host_model (
   input wire logic clk,
   output osdt_pkg::osdt_regreq_t regReq,
   input wire logic [7:0] regRdata
);
   import osdt_pkg::*;
   initial regReq = '0;
   // ==========================================================
   // strokes; idle address and data inverted so stale values never match
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk);
      regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic get(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk);
      d = regRdata;
      regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
   endtask
endmodule

// ### test/osdt_text_window_asserts.sv
// osdt_text_window_asserts: port-level checks of the osd text layer
// assumes only the ports of osdt_text_window; bound after the module
`timescale 1ns/1ps
module osdt_text_window_asserts (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire osdt_pkg::osdt_regreq_t regReq,
   input wire logic [7:0] regRdata,
   input wire osdt_pkg::osdt_scan_t scan,
   input wire osdt_pkg::osdt_pixel_t pixOut
);
   import osdt_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic ctrlEn;
   // ==========================================================
   // enable copy, moved only by control writes
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) ctrlEn <= 1'b0;
      else if (ce && regReq.wr && regReq.addr == A_CTRL) ctrlEn <= regReq.wdata[CTRL_EN];
   end
   sequence dropWrite;
      ce && regReq.wr && regReq.addr == A_DROP;
   endsequence
   sequence dropRead;
      ce && regReq.rd && !regReq.wr && regReq.addr == A_DROP;
   endsequence
   // ==========================================================
   // checks
   chk_drop_readback: assert property (dropWrite ##1 !regReq.wr ##1 dropRead |=> regRdata == $past(regReq.wdata, 3))
      else $error("drop size readback differs from written byte");
   chk_rdata_hold: assert property (!(ce && regReq.rd) |=> $stable(regRdata))
      else $error("read data moved without a read stroke");
   chk_unmapped_zero: assert property (ce && regReq.rd && regReq.addr > A_MASK_EXT |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   chk_idle_dark: assert property (!ctrlEn && !$past(ctrlEn) && !$past(ctrlEn, 2) |-> !pixOut.active && !pixOut.shadowArea)
      else $error("window shown while disabled");
   chk_shadow_band: assert property (pixOut.shadowArea |-> !pixOut.active)
      else $error("shadow band overlaps core window");
   chk_multi_back: assert property (pixOut.attr.multicolour |-> pixOut.attr.backSel == 3'h0)
      else $error("multicolour char carries a back index");
   chk_rom_single: assert property (pixOut.attr.fromRom |-> !pixOut.attr.multicolour)
      else $error("rom char marked multicolour");
   chk_hidden_blink: assert property (pixOut.foreHidden |-> pixOut.attr.foreBlink)
      else $error("fore hidden without fore blink");
endmodule
bind osdt_text_window osdt_text_window_asserts osdt_text_window_asserts_inst (.clk(clk), .sys_rst(sys_rst),
   .ce(ce), .regReq(regReq), .regRdata(regRdata), .scan(scan), .pixOut(pixOut));

// ### test/testbench.sv
// testbench: cursor walk over all write modes and one scan line per zoom
// assumes the host model for register strokes and a 40 MHz clock
`timescale 1ns/1ps
module testbench;
   import osdt_pkg::*;
   logic clk = 1'b0;
   logic sysRst = 1'b1;
   logic ce = 1'b1;
   osdt_regreq_t regReq;
   logic [7:0] regRdata;
   osdt_scan_t scan = '0;
   osdt_pixel_t pixOut;
   int failures = 0;
   int compares = 0;
   int seed = 6;
   int cols, rows, col, row, n, wide, shad;
   logic [7:0] got;
   logic [2:0] act [8] = '{3'h7, 3'h1, 3'h2, 3'h4, 3'h6, 3'h5, 3'h3, 3'h7};
   always #12.5 clk = ~clk;
   osdt_text_window osdt_text_window_inst (.clk(clk), .sys_rst(sysRst), .ce(ce), .regReq(regReq),
      .regRdata(regRdata), .scan(scan), .pixOut(pixOut));
   osdt_host_model osdt_host_model_inst (.clk(clk), .regReq(regReq), .regRdata(regRdata));
   // ==========================================================
   // helpers
   function automatic int rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] seen);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic chk(input logic [7:0] a, input logic [7:0] exp, input string what);
      osdt_host_model_inst.get(a, got);
      cmp(what, exp, got);
   endtask
   task automatic cursor_chk();
      chk(A_CUR_COL, 8'(col), "cursor col");
      chk(A_CUR_ROW, 8'(row), "cursor row");
   endtask
   task automatic close_out();
      if (failures == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ==========================================================
   // watchdog: the whole run needs well under 5000 cycles
   initial begin
      #200000;
      failures++;
      close_out();
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk);
      sysRst = 1'b0;
      chk(A_COLS, RST_DIM, "cols reset");
      chk(A_FRES_H, 8'(RST_FRES_H), "font res reset");
      chk(A_MASK, 8'(RST_MASK), "mask reset");
      chk(8'h13 + 8'(rnd() & 127), 8'h00, "unmapped");
      n = rnd() & 255;
      osdt_host_model_inst.put(A_DROP, 8'(n));
      ce = 1'b0;
      osdt_host_model_inst.put(A_DROP, ~8'(n));
      ce = 1'b1;
      chk(A_DROP, 8'(n), "drop size");
      cols = 2 + (rnd() & 3);
      rows = 2;
      col = cols - 1;
      row = 0;
      osdt_host_model_inst.put(A_COLS, 8'(cols));
      osdt_host_model_inst.put(A_ROWS, 8'(rows));
      osdt_host_model_inst.put(A_CUR_COL, 8'(col));
      osdt_host_model_inst.put(A_CUR_ROW, 8'(row));
      cursor_chk();
      // every write mode; cursor must stay until the last active byte lands
      for (int m = 0; m < 8; m++) begin
         osdt_host_model_inst.put(A_MASK, {5'h0F, m[2:0]});
         for (int b = 0; b < 3; b++) if (act[m][b]) begin
            osdt_host_model_inst.put(PROP_ADDR[b], 8'(rnd()));
            if ((act[m] >> (b + 1)) == 3'h0) begin
               col++;
               if (col == cols) begin
                  col = 0;
                  row = (row + 1 == rows) ? 0 : row + 1;
               end
            end
            cursor_chk();
         end
      end
      osdt_host_model_inst.put(A_FRES_H, 8'h02);
      osdt_host_model_inst.put(A_FRES_V, 8'h02);
      for (int z = 0; z < 4; z++) begin
         osdt_host_model_inst.put(A_CTRL, 8'h60 | 8'(z));
         @(negedge clk);
         scan.frameStart = 1'b1;
         @(negedge clk);
         scan = '{lineStart: 1'b1, default: '0};
         wide = 0;
         shad = 0;
         for (int p = 0; p < 112; p++) begin
            @(negedge clk);
            scan = '{pixEn: p < 108, hPos: 11'(p), default: '0};
            wide += (pixOut.active === 1'b1);
            shad += (pixOut.shadowArea === 1'b1);
         end
         cmp("active width", 8'(cols * (z + 1) * 2), 8'(wide));
         cmp("shadow width", 8'((n >> 4) * (z + 1)), 8'(shad));
      end
      close_out();
   end
endmodule
